// file: inc/dbg_cfg.svh
/*
  Constants of the debug command interpreter: command codes, revision,
  status layout and reset values. Included by the package, the counter, the interpreter and the bench.
*/
// Functional notes
// - Host sends a command byte, then its data; replies follow in listed order.
// - Revision read returns major revision byte first, then minor byte.
// - Status read returns the 8-bit debug status register as one byte.
// - Runtime counter advances once per clock between breakpoints.
// - Runtime counter is 16 bits, starts at zero, saturates at all ones.
// - Runtime counter read returns upper byte, then lower byte.
// - Memory, register, CRC, step, stuff and execute commands overwrite the counter.
// - Control write loads the next host byte into the debug control register.
// - With read protect on, the debug mode bit can be set but never cleared.
// - Control read returns the debug control register as one byte.
// - With read protect on, stuff and execute instruction commands are rejected.
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

`define CMD_REV        8'h00
`define CMD_STAT       8'h02
`define CMD_RTC        8'h03
`define CMD_CTL_WR     8'h04
`define CMD_CTL_RD     8'h05
`define CMD_WR_REG     8'h08
`define CMD_RD_REG     8'h09
`define CMD_WR_MEM     8'h0c
`define CMD_RD_MEM     8'h0d
`define CMD_RD_CRC     8'h0e
`define CMD_STEP       8'h10
`define CMD_STUFF      8'h11
`define CMD_EXEC       8'h12
`define CMD_RSVD_FIRST 8'h13

// Revision values are arbitrary
`define REV_MAJOR      8'h01
`define REV_MINOR      8'h00

`define CTL_MODE_BIT   7
`define CTL_RESET      8'h00
`define CNT_RESET      16'h0000
`define CNT_MAX        16'hffff

`define STAT_MODE_BIT  7
`define STAT_HALT_BIT  6
`define STAT_PROT_BIT  5

`endif

// file: inc/dbg_pkg.sv
/*
  Types of the debug command interpreter.
  Assumes dbg_cfg.svh is on the include path.
*/
`include "dbg_cfg.svh"
package dbg_pkg;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_RESP1 = 2'b01,
    S_RESP2 = 2'b11,
    S_DATA  = 2'b10
  } cmd_state_t;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;
endpackage

// file: inc/dbg_cnt_if.sv
/*
  Carrier between the interpreter and its runtime counter.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface dbg_cnt_if;
  logic        count_en;
  logic        overwrite;
  logic [15:0] value;
  modport ctrl (output count_en, output overwrite, input value);
  modport cnt  (input count_en, input overwrite, output value);
endinterface

// file: logic/runtime_counter.sv
/*
  Saturating 16-bit runtime counter, restarted at zero when a run begins.
  Assumes count_en is high while the core runs between breakpoints.
*/
`timescale 1ns/100ps
`include "dbg_cfg.svh"
module runtime_counter
  import dbg_pkg::*;
(
  input  wire logic mclk,      // System clock
  input  wire logic rst,       // Async reset, high
  dbg_cnt_if.cnt    cnt        // Counter controls and value
);
  count_t value_r;
  logic   run_d_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= cnt.count_en;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      value_r <= `CNT_RESET;
    end else if (cnt.overwrite) begin
      value_r <= `CNT_RESET;
    end else if (cnt.count_en && !run_d_r) begin
      value_r <= `CNT_RESET;
    end else if (cnt.count_en && value_r != `CNT_MAX) begin
      value_r <= value_r + 16'h0001;
    end
  end

  assign cnt.value = value_r;

  property p_cnt_inc;
    @(posedge mclk) disable iff (rst)
      cnt.count_en && run_d_r && !cnt.overwrite && value_r != `CNT_MAX
      |=> value_r == $past(value_r) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("runtime count missed a step");

  property p_cnt_sat;
    @(posedge mclk) disable iff (rst)
      value_r == `CNT_MAX && cnt.count_en && run_d_r && !cnt.overwrite
      |=> value_r == `CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("runtime count wrapped");

  property p_cnt_hold;
    @(posedge mclk) disable iff (rst)
      !cnt.count_en && !cnt.overwrite |=> $stable(value_r);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("runtime count moved at a break");
endmodule

// file: logic/debug_command_interpreter.sv
/*
  Debug command interpreter: decodes host command bytes from the serial
  debug link, answers revision, status, control and runtime counter reads,
  holds the debug control register and forwards other non-reserved commands not rejected by read protect.
  Assumes the link receiver and transmitter run on mclk and move whole
  bytes with valid/ready; option and core state inputs are on mclk too.
*/
`timescale 1ns/100ps
`include "dbg_cfg.svh"
module debug_command_interpreter
  import dbg_pkg::*;
(
  input  wire logic       mclk,                // System clock, 200 MHz
  input  wire logic       rst,                 // Async reset, high
  input  wire logic       rx_valid,            // Host byte present
  input  wire logic [7:0] rx_byte,             // Host byte
  output logic            rx_ready,            // Host byte taken
  output logic            tx_valid,            // Reply byte present
  output logic [7:0]      tx_byte,             // Reply byte
  input  wire logic       tx_ready,            // Reply byte taken
  input  wire logic       read_protect_option, // Read protect enabled
  input  wire logic       cpu_halted,          // Core stopped at a break
  output logic [7:0]      debug_control_reg,   // Debug control register
  output logic            debug_mode_bit,      // Debug mode bit of control
  output logic            fwd_valid,           // Forwarded command pulse
  output logic [7:0]      fwd_cmd              // Forwarded command code
);
  cmd_state_t state_r;
  cmd_state_t state_nxt;
  byte_t      cmd_r;
  byte_t      resp_lo_r;
  logic       two_r;
  logic       rx_ready_r;
  logic       tx_valid_r;
  byte_t      tx_byte_r;
  byte_t      ctl_r;
  logic       fwd_valid_r;
  byte_t      fwd_cmd_r;
  byte_t      status_w;
  logic       rx_fire;
  logic       tx_fire;
  logic       cmd_fire;
  logic       is_local;
  logic       is_reserved;
  logic       is_rejected;
  logic       is_overwrite;
  logic       is_two;

  dbg_cnt_if cnt_if ();

  runtime_counter u_cnt (
    .mclk (mclk),
    .rst  (rst),
    .cnt  (cnt_if)
  );

  assign rx_fire  = rx_valid && rx_ready_r;
  assign tx_fire  = tx_valid_r && tx_ready;
  assign cmd_fire = rx_fire && state_r == S_IDLE;

  // Command classes
  assign is_local = rx_byte == `CMD_REV || rx_byte == `CMD_STAT
                 || rx_byte == `CMD_RTC || rx_byte == `CMD_CTL_WR
                 || rx_byte == `CMD_CTL_RD;
  assign is_reserved = rx_byte >= `CMD_RSVD_FIRST;
  assign is_rejected = read_protect_option
                    && (rx_byte == `CMD_STUFF || rx_byte == `CMD_EXEC);
  assign is_overwrite = rx_byte == `CMD_WR_REG || rx_byte == `CMD_RD_REG
                     || rx_byte == `CMD_WR_MEM || rx_byte == `CMD_RD_MEM
                     || rx_byte == `CMD_RD_CRC || rx_byte == `CMD_STEP
                     || rx_byte == `CMD_STUFF || rx_byte == `CMD_EXEC;
  assign is_two = rx_byte == `CMD_REV || rx_byte == `CMD_RTC;

  always_comb begin
    status_w = 8'h00;
    status_w[`STAT_MODE_BIT] = ctl_r[`CTL_MODE_BIT];
    status_w[`STAT_HALT_BIT] = cpu_halted;
    status_w[`STAT_PROT_BIT] = read_protect_option;
  end

  // Counting runs while the core executes between breakpoints
  assign cnt_if.count_en  = !cpu_halted;
  assign cnt_if.overwrite = cmd_fire && is_overwrite && !is_rejected;

  // Transaction sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (rx_fire && is_local) begin
          if (rx_byte == `CMD_CTL_WR) begin
            state_nxt = S_DATA;
          end else begin
            state_nxt = S_RESP1;
          end
        end
      end
      S_DATA: begin
        if (rx_fire) begin
          state_nxt = S_IDLE;
        end
      end
      S_RESP1: begin
        if (tx_fire) begin
          state_nxt = two_r ? S_RESP2 : S_IDLE;
        end
      end
      S_RESP2: begin
        if (tx_fire) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Host bytes are taken only while no reply is pending
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= state_nxt == S_IDLE || state_nxt == S_DATA;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_r <= 8'h00;
      two_r <= 1'b0;
    end else if (cmd_fire && is_local) begin
      cmd_r <= rx_byte;
      two_r <= is_two;
    end
  end

  // Reply bytes, first byte loaded with the command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_byte_r  <= 8'h00;
      resp_lo_r  <= 8'h00;
    end else if (cmd_fire && is_local && rx_byte != `CMD_CTL_WR) begin
      tx_valid_r <= 1'b1;
      case (rx_byte)
        `CMD_REV: begin
          tx_byte_r <= `REV_MAJOR;
          resp_lo_r <= `REV_MINOR;
        end
        `CMD_STAT: begin
          tx_byte_r <= status_w;
          resp_lo_r <= 8'h00;
        end
        `CMD_RTC: begin
          tx_byte_r <= cnt_if.value[15:8];
          resp_lo_r <= cnt_if.value[7:0];
        end
        default: begin
          tx_byte_r <= ctl_r;
          resp_lo_r <= 8'h00;
        end
      endcase
    end else if (tx_fire && state_r == S_RESP1 && two_r) begin
      tx_byte_r <= resp_lo_r;
    end else if (tx_fire) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Debug control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_r <= `CTL_RESET;
    end else if (rx_fire && state_r == S_DATA) begin
      ctl_r <= rx_byte;
      if (read_protect_option && ctl_r[`CTL_MODE_BIT]) begin
        ctl_r[`CTL_MODE_BIT] <= 1'b1;
      end
    end
  end

  // Commands served elsewhere in the debugger
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fwd_valid_r <= 1'b0;
      fwd_cmd_r   <= 8'h00;
    end else begin
      fwd_valid_r <= cmd_fire && !is_local && !is_reserved && !is_rejected;
      if (cmd_fire && !is_local && !is_reserved && !is_rejected) begin
        fwd_cmd_r <= rx_byte;
      end
    end
  end

  assign rx_ready          = rx_ready_r;
  assign tx_valid          = tx_valid_r;
  assign tx_byte           = tx_byte_r;
  assign debug_control_reg = ctl_r;
  assign debug_mode_bit    = ctl_r[`CTL_MODE_BIT];
  assign fwd_valid         = fwd_valid_r;
  assign fwd_cmd           = fwd_cmd_r;

  property p_no_reply_in_data;
    @(posedge mclk) disable iff (rst)
      state_r == S_DATA |-> !tx_valid_r && rx_ready_r;
  endproperty
  a_no_reply_in_data: assert property (p_no_reply_in_data) else $error("reply during data");

  property p_rev_hi;
    @(posedge mclk) disable iff (rst)
      cmd_fire && rx_byte == `CMD_REV |=> tx_valid_r && tx_byte_r == `REV_MAJOR;
  endproperty
  a_rev_hi: assert property (p_rev_hi) else $error("revision major wrong");

  property p_rev_lo;
    @(posedge mclk) disable iff (rst)
      state_r == S_RESP1 && cmd_r == `CMD_REV && tx_fire
      |=> state_r == S_RESP2 && tx_valid_r && tx_byte_r == `REV_MINOR;
  endproperty
  a_rev_lo: assert property (p_rev_lo) else $error("revision minor wrong");

  property p_stat;
    @(posedge mclk) disable iff (rst)
      cmd_fire && rx_byte == `CMD_STAT
      |=> tx_byte_r == $past(status_w) && !two_r;
  endproperty
  a_stat: assert property (p_stat) else $error("status reply wrong");

  property p_rtc;
    @(posedge mclk) disable iff (rst)
      cmd_fire && rx_byte == `CMD_RTC
      |=> tx_byte_r == $past(cnt_if.value[15:8]) && resp_lo_r == $past(cnt_if.value[7:0]);
  endproperty
  a_rtc: assert property (p_rtc) else $error("runtime reply wrong");

  property p_overwrite;
    @(posedge mclk) disable iff (rst)
      cmd_fire && is_overwrite && !is_rejected |=> cnt_if.value == `CNT_RESET;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("counter not overwritten");

  property p_ctl_wr;
    @(posedge mclk) disable iff (rst)
      rx_fire && state_r == S_DATA && !read_protect_option
      |=> ctl_r == $past(rx_byte) ##0 state_r == S_IDLE;
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");

  property p_mode_sticky;
    @(posedge mclk) disable iff (rst)
      read_protect_option && ctl_r[`CTL_MODE_BIT] |=> ctl_r[`CTL_MODE_BIT];
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("debug mode cleared");

  property p_ctl_rd;
    @(posedge mclk) disable iff (rst)
      cmd_fire && rx_byte == `CMD_CTL_RD |=> tx_valid_r && tx_byte_r == $past(ctl_r);
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read wrong");

  property p_reject;
    @(posedge mclk) disable iff (rst)
      cmd_fire && read_protect_option && (rx_byte == `CMD_STUFF || rx_byte == `CMD_EXEC)
      |-> !cnt_if.overwrite ##1 !fwd_valid_r;
  endproperty
  a_reject: assert property (p_reject) else $error("protected command accepted");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
      cmd_fire && rx_byte >= `CMD_RSVD_FIRST
      |=> state_r == S_IDLE && $stable(ctl_r) && !fwd_valid_r && !tx_valid_r;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved command acted");

  property p_reply_stands;
    @(posedge mclk) disable iff (rst)
      tx_valid_r && !tx_ready
      |=> tx_valid_r && $stable(tx_byte_r);
  endproperty
  a_reply_stands: assert property (p_reply_stands) else $error("reply dropped");

  property p_rx_blocked;
    @(posedge mclk) disable iff (rst)
      tx_valid_r
      |-> !rx_ready_r;
  endproperty
  a_rx_blocked: assert property (p_rx_blocked) else $error("byte taken in reply");

  property p_stat_single;
    @(posedge mclk) disable iff (rst)
      state_r == S_RESP1 && cmd_r == `CMD_STAT && tx_fire
      |=> !tx_valid_r && state_r == S_IDLE;
  endproperty
  a_stat_single: assert property (p_stat_single) else $error("status not single");

  property p_overwrite_fwd;
    @(posedge mclk) disable iff (rst)
      cmd_fire && is_overwrite && !is_rejected
      |=> fwd_valid_r && fwd_cmd_r == $past(rx_byte);
  endproperty
  a_overwrite_fwd: assert property (p_overwrite_fwd) else $error("not forwarded");
endmodule

// file: test/debug_host_model.sv
/*
  Host end of the debug link: offers command and data bytes, takes replies.
  Assumes the interpreter's mclk and rst; bytes change at the falling edge.
*/
`timescale 1ns/100ps
module debug_host_model (
  input  wire logic       mclk,     // System clock
  input  wire logic       rst,      // Async reset, high
  input  wire logic       slow,     // Stall the reply side
  output logic            rx_valid, // Host byte present
  output logic [7:0]      rx_byte,  // Host byte
  input  wire logic       rx_ready, // Host byte taken
  output logic            tx_ready  // Reply byte taken
);
  logic [1:0] stall_r;

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end

  // Replies taken one cycle in four when slow
  always_ff @(negedge mclk or posedge rst) begin
    if (rst) begin
      stall_r  <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      stall_r  <= stall_r + 2'h1;
      tx_ready <= !slow || stall_r == 2'h3;
    end
  end

  // Byte held until taken, then line shows its inverse
  task automatic send(input logic [7:0] b);
    @(negedge mclk);
    rx_valid = 1'b1;
    rx_byte  = b;
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk);
      if (rx_ready === 1'b1) break;
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_byte  = ~b;
  endtask
endmodule

// file: test/test_debug_command_interpreter.sv
/*
  Self-checking bench of the debug command interpreter with a host model.
  Assumes inc/ on the include path and the package compiled first.
*/
`timescale 1ns/100ps
`include "dbg_cfg.svh"
module test_debug_command_interpreter;
  import dbg_pkg::*;
  logic  mclk   = 1'b0;
  logic  rst    = 1'b1;
  logic  prot   = 1'b0;
  logic  halted = 1'b1;
  logic  slow   = 1'b0;
  logic  rx_valid, rx_ready, tx_valid, tx_ready, fwd_valid, mode;
  byte_t rx_byte, tx_byte, ctl, fwd_cmd, last_fwd;
  int    n_fail = 0, n_tests = 0, n_fwd = 0, n, k, seed;
  byte_t exp_q[$];
  byte_t codes[8] = '{`CMD_WR_REG, `CMD_RD_REG, `CMD_WR_MEM, `CMD_RD_MEM,
                      `CMD_RD_CRC, `CMD_STEP, `CMD_STUFF, `CMD_EXEC};

  debug_command_interpreter uut (
    .mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .read_protect_option(prot), .cpu_halted(halted), .debug_control_reg(ctl),
    .debug_mode_bit(mode), .fwd_valid(fwd_valid), .fwd_cmd(fwd_cmd));

  debug_host_model host (
    .mclk(mclk), .rst(rst), .slow(slow), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .tx_ready(tx_ready));

  always #2.5 mclk = ~mclk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Oldest noted reply against each reply handshake
  always @(posedge mclk) begin
    if (fwd_valid === 1'b1) begin
      n_fwd++;
      last_fwd = fwd_cmd;
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("spare reply", 16'h0, 16'h1);
      else check("tx_byte", exp_q.pop_front(), tx_byte);
    end
  end

  task automatic ask(input byte_t c, input byte_t e0, input byte_t e1, input int cnt);
    exp_q.push_back(e0);
    if (cnt == 2) exp_q.push_back(e1);
    host.send(c);
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(negedge mclk);
    check("replies left", 16'h0, 16'(exp_q.size()));
  endtask

  task automatic wr_ctl(input byte_t v, input byte_t e);
    host.send(`CMD_CTL_WR);
    host.send(v);
    repeat (2) @(negedge mclk);
    check("debug_control_reg", e, ctl);
    check("debug_mode_bit", e[7], mode);
  endtask

  task automatic run(input int len);
    @(negedge mclk);
    halted = 1'b0;
    repeat (len) @(negedge mclk);
    halted = 1'b1;
  endtask

  task automatic fwd(input byte_t c, input int inc);
    int f;
    f = n_fwd;
    host.send(c);
    repeat (2) @(negedge mclk);
    check("forward count", 16'(f + inc), 16'(n_fwd));
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(5.0 * 90000);
    n_fail++;
    wrap_up();
  end

  initial begin
    seed = $urandom(17);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    check("ctl after reset", `CTL_RESET, ctl);
    $display("Test reset done");
    ask(`CMD_REV, `REV_MAJOR, `REV_MINOR, 2);
    slow = 1'b1;
    ask(`CMD_REV, `REV_MAJOR, `REV_MINOR, 2);
    $display("Test revision done");
    repeat (4) begin
      n = $urandom;
      slow = n[8];
      wr_ctl(n[7:0], n[7:0]);
      ask(`CMD_CTL_RD, n[7:0], 8'h00, 1);
      halted = n[9];
      ask(`CMD_STAT, {n[7], n[9], 1'b0, 5'h00}, 8'h00, 1);
    end
    halted = 1'b1;
    $display("Test control and status done");
    k = 20 + $urandom % 60;
    run(k);
    ask(`CMD_RTC, 8'h00, 8'(k - 1), 2);
    ask(`CMD_RTC, 8'h00, 8'(k - 1), 2);
    foreach (codes[i]) begin
      run(k);
      fwd(codes[i], 1);
      check("fwd_cmd", codes[i], last_fwd);
      ask(`CMD_RTC, 8'h00, 8'h00, 2);
    end
    $display("Test counter overwrite done");
    prot = 1'b1;
    run(k);
    fwd(`CMD_STUFF, 0);
    fwd(`CMD_EXEC, 0);
    ask(`CMD_RTC, 8'h00, 8'(k - 1), 2);
    wr_ctl(8'h80, 8'h80);
    wr_ctl(8'h05, 8'h85);
    ask(`CMD_STAT, 8'he0, 8'h00, 1);
    $display("Test read protect done");
    n = 19 + $urandom % 237;
    fwd(8'(n), 0);
    check("ctl kept", 8'h85, ctl);
    ask(`CMD_RTC, 8'h00, 8'(k - 1), 2);
    $display("Test reserved code done");
    prot = 1'b0;
    run(66000);
    ask(`CMD_RTC, 8'hff, 8'hff, 2);
    $display("Test saturation done");
    wrap_up();
  end
endmodule
